// ===== verilog/abo_exec.sv
// execute unit for and-with-file, and-literal, bit-clear and bit-set
// Behaviour
// RULE1: 000101 word ANDs W with file f
// RULE2: d=0 writes W, d=1 writes file
// RULE3: 1110 word ANDs W with literal
// RULE4: literal AND goes to W, one cycle
// RULE5: 0100 word clears bit b of f
// RULE6: 0101 word sets bit b of f
// RULE7: AND sets zero flag on zero result
// RULE8: I/O ports read pins, not latches
// RULE9: timer write clears assigned prescaler
module abo_exec
  import abo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [DATA_W-1:0] file_latch_data,
  input wire logic [DATA_W-1:0] file_pin_data,
  input wire logic prescaler_on_timer,
  output logic [DATA_W-1:0] w_r,
  output logic zero_r,
  output logic file_wr_en_r,
  output logic [FADDR_W-1:0] file_wr_addr_r,
  output logic [DATA_W-1:0] file_wr_data_r,
  output logic prescaler_clr_r
);
  abo_op_t op;
  logic [FADDR_W-1:0] faddr;
  logic [BSEL_W-1:0] bsel;
  logic [DATA_W-1:0] lit;
  logic dest;
  logic [DATA_W-1:0] src;
  logic [DATA_W-1:0] alu_result;
  logic alu_zero;
  logic writes_w_nxt;
  logic writes_file_nxt;
  logic is_and_nxt;

  // opcode decode from the top of the word
  function automatic abo_op_t decode_op(input logic [INSTR_W-1:0] word);
    abo_op_t res;
    res = ABO_OP_NONE;
    if (word[INSTR_W-1:OP6_LSB] == AND_W_WITH_FILE_OP) begin
      res = ABO_OP_AND_FILE;
    end else if (word[INSTR_W-1:OP4_LSB] == AND_LITERAL_WITH_W_OP) begin
      res = ABO_OP_AND_LIT;
    end else if (word[INSTR_W-1:OP4_LSB] == BIT_CLEAR_FILE_OP) begin
      res = ABO_OP_BIT_CLEAR;
    end else if (word[INSTR_W-1:OP4_LSB] == BIT_SET_FILE_OP) begin
      res = ABO_OP_BIT_SET;
    end
    return res;
  endfunction

  // true for the addresses of the I/O port registers
  function automatic logic is_io_port(input logic [FADDR_W-1:0] addr);
    return (addr >= IO_PORT_FIRST_ADDR) && (addr <= IO_PORT_LAST_ADDR);
  endfunction

  // RULE3 literal and operand fields
  // an idle cycle decodes as no operation
  assign op = instr_valid ? decode_op(instr) : ABO_OP_NONE;
  assign faddr = instr[FADDR_LSB +: FADDR_W];
  assign bsel = instr[BSEL_LSB +: BSEL_W];
  assign lit = instr[LIT_LSB +: DATA_W];
  assign dest = instr[DEST_BIT];

  // RULE8 pin values as operand
  // a port read-modify-write must see the pins, else an input pin held low
  // by the outside would be written back from a stale latch
  assign src = is_io_port(faddr) ? file_pin_data : file_latch_data;

  abo_alu u_alu (
    .op(op),
    .w_val(w_r),
    .src_val(src),
    .lit_val(lit),
    .bit_sel(bsel),
    .result(alu_result),
    .result_zero(alu_zero)
  );

  // RULE2 destination select
  // RULE4 literal always to W
  always_comb begin
    writes_w_nxt = 1'b0;
    writes_file_nxt = 1'b0;
    is_and_nxt = 1'b0;
    case (op)
      ABO_OP_AND_FILE: begin
        is_and_nxt = 1'b1;
        writes_w_nxt = (dest == DEST_W);
        writes_file_nxt = (dest == DEST_FILE);
      end
      ABO_OP_AND_LIT: begin
        is_and_nxt = 1'b1;
        writes_w_nxt = 1'b1;
      end
      ABO_OP_BIT_CLEAR, ABO_OP_BIT_SET: writes_file_nxt = 1'b1;
      default: writes_w_nxt = 1'b0;
    endcase
  end

  // RULE1 working register update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_r <= W_RESET;
    end else if (writes_w_nxt) begin
      w_r <= alu_result;
    end
  end

  // RULE7 zero flag from AND result
  // bit ops leave the flag alone so flag tests survive them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_r <= ZERO_RESET;
    end else if (is_and_nxt) begin
      zero_r <= alu_zero;
    end
  end

  // RULE5 RULE6 file write port, one cycle pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      file_wr_en_r <= 1'b0;
      file_wr_addr_r <= '0;
      file_wr_data_r <= '0;
    end else begin
      file_wr_en_r <= writes_file_nxt;
      if (writes_file_nxt) begin
        file_wr_addr_r <= faddr;
        file_wr_data_r <= alu_result;
      end
    end
  end

  // RULE9 prescaler clear on timer write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescaler_clr_r <= 1'b0;
    end else begin
      prescaler_clr_r <= writes_file_nxt && (faddr == TIMER_ZERO_COUNT_ADDR)
                         && prescaler_on_timer;
    end
  end

  // checks beside the logic
  // W is only narrowed here; loading it belongs to instructions outside this unit
  a_and_file_w: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    (op == ABO_OP_AND_FILE && dest == DEST_W) |=> (w_r == ($past(w_r) & $past(src))))
    else $error("and with file to W gave wrong W");

  a_and_file_dest: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    (op == ABO_OP_AND_FILE && dest == DEST_FILE) |=>
      (file_wr_en_r && w_r == $past(w_r) && file_wr_data_r == ($past(w_r) & $past(src))))
    else $error("and with file to file misrouted");

  a_and_lit_w: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    (op == ABO_OP_AND_LIT) |=> (w_r == ($past(w_r) & $past(lit))))
    else $error("and literal gave wrong W");

  a_lit_no_file: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    (op == ABO_OP_AND_LIT) |=> !file_wr_en_r)
    else $error("and literal wrote a file register");

  a_bit_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    (op == ABO_OP_BIT_CLEAR) |=> (file_wr_en_r && file_wr_addr_r == $past(faddr)
      && file_wr_data_r == ($past(src) & ~(DATA_W'(1) << $past(bsel)))
      && $stable(zero_r) && $stable(w_r)))
    else $error("bit clear wrong");

  a_bit_set: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    (op == ABO_OP_BIT_SET) |=> (file_wr_en_r && file_wr_data_r[$past(bsel)]
      && file_wr_data_r == ($past(src) | (DATA_W'(1) << $past(bsel)))
      && $stable(zero_r)))
    else $error("bit set wrong");

  a_set_addr: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    (op == ABO_OP_BIT_SET) |=> (file_wr_addr_r == $past(faddr) && $stable(w_r)))
    else $error("bit set wrote the wrong register");

  // the flag must follow the op that was taken, not the one now on the bus
  a_zero_flag: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    (op == ABO_OP_AND_LIT || op == ABO_OP_AND_FILE) |=>
      (zero_r == (($past(op) == ABO_OP_AND_LIT ? $past(w_r) & $past(lit)
        : $past(w_r) & $past(src)) == '0)))
    else $error("zero flag wrong after and");

  // refused words and idle cycles must raise no write or prescaler pulse and leave W and the zero flag alone
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    (op == ABO_OP_NONE) |=>
      (!file_wr_en_r && !prescaler_clr_r && $stable(w_r) && $stable(zero_r)))
    else $error("idle or unknown word changed state");

  a_pin_source: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    (op == ABO_OP_BIT_SET && is_io_port(faddr)) |=>
      (file_wr_data_r == ($past(file_pin_data) | (DATA_W'(1) << $past(bsel)))))
    else $error("port operand not taken from pins");

  a_port_and: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    (op == ABO_OP_AND_FILE && dest == DEST_FILE && is_io_port(faddr)) |=>
      (file_wr_data_r == ($past(w_r) & $past(file_pin_data))))
    else $error("port and operand not taken from pins");

  a_port_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    (op == ABO_OP_BIT_CLEAR && is_io_port(faddr)) |=>
      (file_wr_data_r == ($past(file_pin_data) & ~(DATA_W'(1) << $past(bsel)))))
    else $error("port clear operand not taken from pins");

  // a timer write with the prescaler assigned must always produce the pulse
  a_presc_needed: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    ((op == ABO_OP_BIT_SET || op == ABO_OP_BIT_CLEAR
      || (op == ABO_OP_AND_FILE && dest == DEST_FILE))
      && faddr == TIMER_ZERO_COUNT_ADDR && prescaler_on_timer) |=> prescaler_clr_r)
    else $error("timer write left prescaler uncleared");

  a_presc_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    prescaler_clr_r |-> (file_wr_en_r && file_wr_addr_r == TIMER_ZERO_COUNT_ADDR
      && $past(prescaler_on_timer)))
    else $error("prescaler cleared without timer write");
endmodule

// ===== verilog/abo_pkg.sv
// shared constants and types for the and / bit-set / bit-clear execute unit
package abo_pkg;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int BSEL_W = 3;
  // opcode fields, matched against the top bits of the word
  localparam logic [5:0] AND_W_WITH_FILE_OP = 6'h05; // 000101
  localparam logic [3:0] AND_LITERAL_WITH_W_OP = 4'hE; // 1110
  localparam logic [3:0] BIT_CLEAR_FILE_OP = 4'h4; // 0100
  localparam logic [3:0] BIT_SET_FILE_OP = 4'h5; // 0101
  // field positions inside the instruction word
  localparam int OP6_LSB = 6;
  localparam int OP4_LSB = 8;
  localparam int DEST_BIT = 5;
  localparam int BSEL_LSB = 5;
  localparam int FADDR_LSB = 0;
  localparam int LIT_LSB = 0;
  // destination encoding
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // file addresses with side effects
  localparam logic [FADDR_W-1:0] TIMER_ZERO_COUNT_ADDR = 5'h01;
  localparam logic [FADDR_W-1:0] IO_PORT_FIRST_ADDR = 5'h05;
  localparam logic [FADDR_W-1:0] IO_PORT_LAST_ADDR = 5'h07;
  // reset values
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;

  typedef enum logic [2:0] {
    ABO_OP_NONE,
    ABO_OP_AND_FILE,
    ABO_OP_AND_LIT,
    ABO_OP_BIT_CLEAR,
    ABO_OP_BIT_SET
  } abo_op_t;
endpackage

// ===== verilog/abo_alu.sv
// combinational result and zero detect for the four operations
module abo_alu
  import abo_pkg::*;
(
  input wire abo_op_t op,
  input wire logic [DATA_W-1:0] w_val,
  input wire logic [DATA_W-1:0] src_val,
  input wire logic [DATA_W-1:0] lit_val,
  input wire logic [BSEL_W-1:0] bit_sel,
  output logic [DATA_W-1:0] result,
  output logic result_zero
);
  logic [DATA_W-1:0] bit_mask;

  // one-hot mask of the addressed bit
  assign bit_mask = DATA_W'(1) << bit_sel;

  // operation select; unknown ops pass the source through unchanged
  always_comb begin
    case (op)
      ABO_OP_AND_FILE: result = w_val & src_val;
      ABO_OP_AND_LIT: result = w_val & lit_val;
      ABO_OP_BIT_CLEAR: result = src_val & ~bit_mask;
      ABO_OP_BIT_SET: result = src_val | bit_mask;
      default: result = src_val;
    endcase
  end

  assign result_zero = (result == '0);
endmodule

// ===== tb/abo_exec_tb.sv
// self-checking testbench for the and / bit-set / bit-clear execute unit
module abo_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import abo_pkg::*;

  logic clk;
  logic rst_b;
  logic instr_valid;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0] file_latch_data;
  logic [DATA_W-1:0] file_pin_data;
  logic prescaler_on_timer;
  logic [DATA_W-1:0] w_r;
  logic zero_r;
  logic file_wr_en_r;
  logic [FADDR_W-1:0] file_wr_addr_r;
  logic [DATA_W-1:0] file_wr_data_r;
  logic prescaler_clr_r;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  abo_exec i_abo_exec (
    .clk(clk),
    .rst_b(rst_b),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_latch_data(file_latch_data),
    .file_pin_data(file_pin_data),
    .prescaler_on_timer(prescaler_on_timer),
    .w_r(w_r),
    .zero_r(zero_r),
    .file_wr_en_r(file_wr_en_r),
    .file_wr_addr_r(file_wr_addr_r),
    .file_wr_data_r(file_wr_data_r),
    .prescaler_clr_r(prescaler_clr_r)
  );

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a hang is cut short well past the expected run of about 34 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // entered at a falling edge; inputs stay put until the next call, so calls may run back to back
  task automatic run(input logic v, input logic [11:0] word, input logic [7:0] lat, pin);
    instr_valid = v;
    instr = word;
    file_latch_data = lat;
    file_pin_data = pin;
    @(negedge clk);
  endtask

  task automatic test_and_forms();
    run(1'b1, {AND_W_WITH_FILE_OP, DEST_FILE, 5'h03}, 8'hC2, 8'h00);
    check("and file en", 8'(file_wr_en_r), 8'h01);
    check("and file addr", 8'(file_wr_addr_r), 8'h03);
    check("and file data", file_wr_data_r, 8'h00);
    check("and file zero", 8'(zero_r), 8'h01);
    run(1'b1, {AND_LITERAL_WITH_W_OP, 8'h5F}, 8'hFF, 8'hFF);
    check("literal no write", 8'(file_wr_en_r), 8'h00);
    check("literal w", w_r, 8'h00);
    check("literal zero", 8'(zero_r), 8'h01);
    run(1'b1, {AND_W_WITH_FILE_OP, DEST_W, 5'h04}, 8'hFF, 8'hFF);
    check("and w no write", 8'(file_wr_en_r), 8'h00);
    check("and w result", w_r, 8'h00);
    $display("test and forms done");
  endtask

  // every bit position, set then cleared, back to back
  task automatic test_bits();
    for (int b = 0; b < 8; b++) begin
      run(1'b1, {BIT_SET_FILE_OP, 3'(b), 5'h02}, 8'h0A, 8'h55);
      check("set data", file_wr_data_r, 8'h0A | (8'h01 << b));
      check("set addr", 8'(file_wr_addr_r), 8'h02);
      run(1'b1, {BIT_CLEAR_FILE_OP, 3'(b), 5'h1F}, 8'hC7, 8'h00);
      check("clear data", file_wr_data_r, 8'hC7 & ~(8'h01 << b));
      check("clear en", 8'(file_wr_en_r), 8'h01);
      check("flag kept", 8'(zero_r), 8'h01);
    end
    // port registers take the pin values, not the latch
    run(1'b1, {BIT_SET_FILE_OP, 3'd3, IO_PORT_LAST_ADDR - 5'h01}, 8'h00, 8'h81);
    check("port set", file_wr_data_r, 8'h89);
    run(1'b1, {BIT_CLEAR_FILE_OP, 3'd7, IO_PORT_FIRST_ADDR}, 8'hFF, 8'h80);
    check("port clear", file_wr_data_r, 8'h00);
    $display("test bits done");
  endtask

  task automatic test_timer_and_refused();
    prescaler_on_timer = 1'b1;
    run(1'b1, {BIT_SET_FILE_OP, 3'd0, TIMER_ZERO_COUNT_ADDR}, 8'h00, 8'h00);
    check("timer clear", 8'(prescaler_clr_r), 8'h01);
    run(1'b1, {AND_W_WITH_FILE_OP, DEST_FILE, TIMER_ZERO_COUNT_ADDR}, 8'h00, 8'h00);
    check("timer and d1", 8'(prescaler_clr_r), 8'h01);
    run(1'b1, {AND_W_WITH_FILE_OP, DEST_W, TIMER_ZERO_COUNT_ADDR}, 8'h00, 8'h00);
    check("timer d0", 8'(prescaler_clr_r), 8'h00);
    run(1'b1, {BIT_SET_FILE_OP, 3'd0, 5'h02}, 8'h00, 8'h00);
    check("other addr", 8'(prescaler_clr_r), 8'h00);
    prescaler_on_timer = 1'b0;
    run(1'b1, {BIT_CLEAR_FILE_OP, 3'd0, TIMER_ZERO_COUNT_ADDR}, 8'h00, 8'h00);
    check("not assigned", 8'(prescaler_clr_r), 8'h00);
    run(1'b1, 12'h800, 8'hFF, 8'hFF);
    check("other opcode", 8'(file_wr_en_r), 8'h00);
    check("other opcode zero", 8'(zero_r), 8'h01);
    run(1'b0, {BIT_SET_FILE_OP, 3'd1, 5'h02}, 8'h00, 8'h00);
    check("no valid", 8'(file_wr_en_r), 8'h00);
    $display("test timer and refused done");
  endtask

  // reset in mid run clears the write port and flag, then work resumes at once
  task automatic test_reset_mid();
    run(1'b1, {BIT_SET_FILE_OP, 3'd6, 5'h1E}, 8'h11, 8'h00);
    check("pre reset data", file_wr_data_r, 8'h51);
    rst_b = 1'b0;
    run(1'b0, 12'h000, 8'h00, 8'h00);
    check("mid reset en", 8'(file_wr_en_r), 8'h00);
    check("mid reset addr", 8'(file_wr_addr_r), 8'h00);
    check("mid reset data", file_wr_data_r, 8'h00);
    check("mid reset zero", 8'(zero_r), 8'h00);
    rst_b = 1'b1;
    run(1'b1, {BIT_CLEAR_FILE_OP, 3'd0, 5'h03}, 8'h0F, 8'h00);
    check("after reset data", file_wr_data_r, 8'h0E);
    check("after reset zero", 8'(zero_r), 8'h00);
    $display("test reset mid done");
  endtask

  initial begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    file_latch_data = 8'h00;
    file_pin_data = 8'h00;
    prescaler_on_timer = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    check("reset w", w_r, W_RESET);
    check("reset zero", 8'(zero_r), 8'h00);
    test_and_forms();
    test_bits();
    test_timer_and_refused();
    test_reset_mid();
    tally_and_finish();
  end
endmodule
